// >>> hw/slpc_pkg.sv
// shared constants and carrier types for the serial link parameter register bank
// assumes an 8-bit register port with 12-bit addresses and eight receive lanes
`default_nettype none

package slpc_pkg;

	// geometry
	localparam int ADDR_W  = 12;
	localparam int DATA_W  = 8;
	localparam int LANES   = 8;
	localparam int CNT_W   = 8;

	// register offsets
	localparam logic [11:0] OFS_SUBCLASS_AND_BITS     = 12'h458;
	localparam logic [11:0] OFS_SAMPLES_AND_VERSION   = 12'h459;
	localparam logic [11:0] OFS_DENSITY_AND_CTRL      = 12'h45A;
	localparam logic [11:0] OFS_LANE0_PARAM_CHECKSUM  = 12'h45D;
	localparam logic [11:0] OFS_LANE_ERR_CNT_MONITOR  = 12'h46B;

	// field positions
	localparam int SUBCLASS_LSB   = 5;
	localparam int BITS_LSB       = 0;
	localparam int VERSION_LSB    = 5;
	localparam int SAMPLES_LSB    = 0;
	localparam int DENSITY_BIT    = 7;
	localparam int CTRLW_LSB      = 0;
	localparam int MONITOR_LANE_SELECT_LSB    = 4;
	localparam int CNTSEL_LSB     = 0;

	// reset values
	localparam logic [2:0] RST_SUBCLASS = 3'h1;
	localparam logic [4:0] RST_BITS     = 5'h0F;
	localparam logic [2:0] RST_VERSION  = 3'h1;
	localparam logic [4:0] RST_SAMPLES  = 5'h00;
	localparam logic       RST_DENSITY  = 1'h1;
	localparam logic [4:0] RST_CTRLW    = 5'h00;
	localparam logic [7:0] RST_CHECKSUM = 8'h45;
	localparam logic [2:0] RST_MONITOR_LANE_SELECT  = 3'h0;
	localparam logic [1:0] RST_CNTSEL   = 2'h0;

	// decode values
	localparam logic [2:0] VERSION_A    = 3'h0;
	localparam logic [2:0] VERSION_B    = 3'h1;
	localparam logic [4:0] SAMPLES_TWO  = 5'h01;

	// counter kinds
	typedef enum logic [1:0] {
		SLPC_CNT_BAD_DISP = 2'h0,
		SLPC_CNT_NOT_IN_TABLE = 2'h1,
		SLPC_CNT_UNEXP_CTRL = 2'h2
	} slpc_cnt_e;

	// programmed link parameters
	typedef struct packed {
		logic [2:0] subclass_version;
		logic [4:0] total_bits_per_sample;
		logic [2:0] protocol_version;
		logic [4:0] samples_per_frame;
		logic       high_density_flag;
		logic [4:0] control_words_per_frame;
		logic [7:0] lane_zero_param_sum;
	} slpc_params_s;

	// per-lane error events, one bit per lane
	typedef struct packed {
		logic [7:0] bad_disparity;
		logic [7:0] not_in_table;
		logic [7:0] unexpected_control;
	} slpc_err_events_s;

endpackage : slpc_pkg

`default_nettype wire

// >>> hw/slpc_lane_counters.sv
// three saturating error counters for one receive lane
// assumes event inputs are one-cycle pulses on i_clk
`default_nettype none

module slpc_lane_counters
	import slpc_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// error events
	input  wire logic                 i_bad_disparity,
	input  wire logic                 i_not_in_table,
	input  wire logic                 i_unexpected_control,
	// counts
	output logic [slpc_pkg::CNT_W-1:0] o_bad_disparity_count,
	output logic [slpc_pkg::CNT_W-1:0] o_not_in_table_count,
	output logic [slpc_pkg::CNT_W-1:0] o_unexpected_control_count
);

	logic [CNT_W-1:0] bad_disparity_count;
	logic [CNT_W-1:0] not_in_table_count;
	logic [CNT_W-1:0] unexpected_control_count;
	logic [CNT_W-1:0] next_bad_disparity_count;
	logic [CNT_W-1:0] next_not_in_table_count;
	logic [CNT_W-1:0] next_unexpected_control_count;

	// saturate rather than wrap so a busy lane never reads as quiet
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic ev);
		bump = (ev && c != {CNT_W{1'b1}}) ? c + 1'b1 : c;
	endfunction

	always_comb begin
		next_bad_disparity_count      = bump(bad_disparity_count, i_bad_disparity);
		next_not_in_table_count       = bump(not_in_table_count, i_not_in_table);
		next_unexpected_control_count = bump(unexpected_control_count, i_unexpected_control);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bad_disparity_count      <= '0;
			not_in_table_count       <= '0;
			unexpected_control_count <= '0;
		end else begin
			bad_disparity_count      <= next_bad_disparity_count;
			not_in_table_count       <= next_not_in_table_count;
			unexpected_control_count <= next_unexpected_control_count;
		end
	end

	assign o_bad_disparity_count      = bad_disparity_count;
	assign o_not_in_table_count       = not_in_table_count;
	assign o_unexpected_control_count = unexpected_control_count;

endmodule // slpc_lane_counters

`default_nettype wire

// >>> hw/slpc_regs.sv
// link parameter register bank with indirect per-lane error counter readback
// assumes a synchronous 8-bit register port and lane logic on the same clock
`default_nettype none

module slpc_regs
	import slpc_pkg::*;
(
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	// register port
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	input  wire logic [slpc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [slpc_pkg::DATA_W-1:0] i_wdata,
	output logic [slpc_pkg::DATA_W-1:0]    o_rdata,
	output logic                           o_rvalid,
	// lane side
	input  wire slpc_pkg::slpc_err_events_s i_err_events,
	input  wire logic                      i_lane0_valid,
	input  wire slpc_pkg::slpc_params_s    i_lane0_params,
	// decoded configuration
	output slpc_pkg::slpc_params_s         o_params,
	output logic                           o_version_b,
	output logic                           o_samples_two,
	output logic                           o_lane0_mismatch
);

	import slpc_pkg::*;

	slpc_params_s     params;
	slpc_params_s     next_params;
	logic [2:0]       lane_sel;
	logic [2:0]       next_lane_sel;
	logic [1:0]       cnt_sel;
	logic [1:0]       next_cnt_sel;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic             rvalid;
	logic             next_rvalid;
	logic             version_b;
	logic             next_version_b;
	logic             samples_two;
	logic             next_samples_two;
	logic             mismatch;
	logic             next_mismatch;

	logic [CNT_W-1:0] cnt_bad  [LANES];
	logic [CNT_W-1:0] cnt_nit  [LANES];
	logic [CNT_W-1:0] cnt_uek  [LANES];

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			slpc_lane_counters u_cnt (
				.i_clk                      (i_clk),
				.i_rst                      (i_rst),
				.i_bad_disparity            (i_err_events.bad_disparity[g]),
				.i_not_in_table             (i_err_events.not_in_table[g]),
				.i_unexpected_control       (i_err_events.unexpected_control[g]),
				.o_bad_disparity_count      (cnt_bad[g]),
				.o_not_in_table_count       (cnt_nit[g]),
				.o_unexpected_control_count (cnt_uek[g])
			);
		end
	endgenerate

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// register writes
	always_comb begin
		next_params   = params;
		next_lane_sel = lane_sel;
		next_cnt_sel  = cnt_sel;
		if (i_wr) begin
			if (hit(i_addr, OFS_SUBCLASS_AND_BITS)) begin
				next_params.subclass_version      = i_wdata[SUBCLASS_LSB +: 3];
				next_params.total_bits_per_sample = i_wdata[BITS_LSB +: 5];
			end else if (hit(i_addr, OFS_SAMPLES_AND_VERSION)) begin
				next_params.protocol_version  = i_wdata[VERSION_LSB +: 3];
				next_params.samples_per_frame = i_wdata[SAMPLES_LSB +: 5];
			end else if (hit(i_addr, OFS_DENSITY_AND_CTRL)) begin
				next_params.high_density_flag       = i_wdata[DENSITY_BIT];
				next_params.control_words_per_frame = i_wdata[CTRLW_LSB +: 5];
			end else if (hit(i_addr, OFS_LANE0_PARAM_CHECKSUM)) begin
				next_params.lane_zero_param_sum = i_wdata;
			end else if (hit(i_addr, OFS_LANE_ERR_CNT_MONITOR)) begin
				next_lane_sel = i_wdata[MONITOR_LANE_SELECT_LSB +: 3];
				next_cnt_sel  = i_wdata[CNTSEL_LSB +: 2];
			end
		end
	end

	// register reads; selects are write-only so the monitor returns only the count
	always_comb begin
		// read data falls back to zero between answers so no stale count lingers
		next_rdata  = '0;
		next_rvalid = i_rd;
		if (i_rd) begin
			if (hit(i_addr, OFS_SUBCLASS_AND_BITS)) begin
				next_rdata = {params.subclass_version, params.total_bits_per_sample};
			end else if (hit(i_addr, OFS_SAMPLES_AND_VERSION)) begin
				next_rdata = {params.protocol_version, params.samples_per_frame};
			end else if (hit(i_addr, OFS_DENSITY_AND_CTRL)) begin
				next_rdata = {params.high_density_flag, 2'h0, params.control_words_per_frame};
			end else if (hit(i_addr, OFS_LANE0_PARAM_CHECKSUM)) begin
				next_rdata = params.lane_zero_param_sum;
			end else if (hit(i_addr, OFS_LANE_ERR_CNT_MONITOR)) begin
				case (slpc_cnt_e'(cnt_sel))
					SLPC_CNT_BAD_DISP:     next_rdata = cnt_bad[lane_sel];
					SLPC_CNT_NOT_IN_TABLE: next_rdata = cnt_nit[lane_sel];
					SLPC_CNT_UNEXP_CTRL:   next_rdata = cnt_uek[lane_sel];
					default:               next_rdata = '0;
				endcase
			end
		end
	end

	// decoded configuration flags
	always_comb begin
		next_version_b   = (params.protocol_version == VERSION_B);
		next_samples_two = (params.samples_per_frame == SAMPLES_TWO);
	end

	// lane 0 comparison; the verdict holds between alignment sequences
	always_comb begin
		next_mismatch    = mismatch;
		if (i_lane0_valid) begin
			next_mismatch = (i_lane0_params != params);
		end
	end

	// parameter registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			params.subclass_version        <= RST_SUBCLASS;
			params.total_bits_per_sample   <= RST_BITS;
			params.protocol_version        <= RST_VERSION;
			params.samples_per_frame       <= RST_SAMPLES;
			params.high_density_flag       <= RST_DENSITY;
			params.control_words_per_frame <= RST_CTRLW;
			params.lane_zero_param_sum     <= RST_CHECKSUM;
		end else begin
			params <= next_params;
		end
	end

	// selects are write-only, so software rewrites them after every reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lane_sel <= RST_MONITOR_LANE_SELECT;
			cnt_sel  <= RST_CNTSEL;
		end else begin
			lane_sel <= next_lane_sel;
			cnt_sel  <= next_cnt_sel;
		end
	end

	// read answer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata  <= '0;
			rvalid <= 1'h0;
		end else begin
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// decoded flags leave from flops, one cycle behind the register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			version_b   <= 1'h0;
			samples_two <= 1'h0;
		end else begin
			version_b   <= next_version_b;
			samples_two <= next_samples_two;
		end
	end

	// lane 0 verdict
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mismatch <= 1'h0;
		end else begin
			mismatch <= next_mismatch;
		end
	end

	assign o_params         = params;
	assign o_rdata          = rdata;
	assign o_rvalid         = rvalid;
	assign o_version_b      = version_b;
	assign o_samples_two    = samples_two;
	assign o_lane0_mismatch = mismatch;

endmodule // slpc_regs

`default_nettype wire

// >>> sim/slpc_chk.sv
// port assertions for slpc_regs
// assumes one clock, async high reset
`default_nettype none
module slpc_chk
	import slpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [slpc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [slpc_pkg::DATA_W-1:0] i_wdata,
	input wire logic [slpc_pkg::DATA_W-1:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic i_lane0_valid,
	input wire slpc_pkg::slpc_params_s i_lane0_params,
	input wire slpc_pkg::slpc_params_s o_params,
	input wire logic o_version_b,
	input wire logic o_samples_two,
	input wire logic o_lane0_mismatch
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_read_answer: assert property (1'b1 |=> o_rvalid == $past(i_rd))
		else $error("read answer timing wrong");
	a_idle_rdata: assert property (!o_rvalid |-> o_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_version_dec: assert property (
		1'b1 |=> o_version_b == ($past(o_params.protocol_version) == VERSION_B))
		else $error("version decode wrong");
	a_samples_dec: assert property (
		1'b1 |=> o_samples_two == ($past(o_params.samples_per_frame) == SAMPLES_TWO))
		else $error("samples decode wrong");
	a_reserved_zero: assert property (
		i_rd && i_addr == OFS_DENSITY_AND_CTRL |=> o_rdata ==
		{$past(o_params.high_density_flag), 2'h0, $past(o_params.control_words_per_frame)})
		else $error("density register read wrong");
	a_checksum_store: assert property (
		i_wr && i_addr == OFS_LANE0_PARAM_CHECKSUM |=>
		o_params.lane_zero_param_sum == $past(i_wdata))
		else $error("checksum not stored");
	a_mismatch_hold: assert property (!i_lane0_valid |=> $stable(o_lane0_mismatch))
		else $error("mismatch moved without lane data");
	a_mismatch_set: assert property (
		i_lane0_valid |=> o_lane0_mismatch == ($past(i_lane0_params) != $past(o_params)))
		else $error("mismatch value wrong");
endmodule // slpc_chk
bind slpc_regs slpc_chk i_chk (.i_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
	.o_rvalid, .i_lane0_valid, .i_lane0_params, .o_params, .o_version_b, .o_samples_two,
	.o_lane0_mismatch);
`default_nettype wire

// >>> sim/slpc_lane_tx.sv
// lane-side model: error pulses and lane 0 alignment data
// assumes the bench calls its tasks; drives on falling edges
`default_nettype none
module slpc_lane_tx
	import slpc_pkg::*;
(
	input wire logic i_clk,
	output slpc_pkg::slpc_err_events_s o_err_events,
	output logic o_lane0_valid,
	output slpc_pkg::slpc_params_s o_lane0_params
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_err_events = '0;
		o_lane0_valid = 1'b0;
		o_lane0_params = '1;
	end
	task automatic pulse(input logic [1:0] kind, input logic [2:0] lane, input int n, input int gap);
		int idx;
		idx = (2 - int'(kind)) * 8 + int'(lane);
		for (int k = 0; k < n; k++) begin
			@(negedge i_clk);
			o_err_events = 24'h000001 << idx;
			repeat (gap) begin
				@(negedge i_clk);
				o_err_events = '0;
			end
		end
		@(negedge i_clk);
		o_err_events = '0;
	endtask
	// lane 0 data, garbage when idle
	task automatic send(input slpc_params_s p);
		@(negedge i_clk);
		o_lane0_valid = 1'b1;
		o_lane0_params = p;
		@(negedge i_clk);
		o_lane0_valid = 1'b0;
		o_lane0_params = ~p;
	endtask
endmodule // slpc_lane_tx
`default_nettype wire

// >>> sim/tb_top.sv
// bench for slpc_regs: register port by strobes, lane side by model
// assumes 100 MHz clock and async high reset
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import slpc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [11:0] i_addr = '0;
	logic [7:0] i_wdata = '0;
	logic [7:0] o_rdata;
	logic o_rvalid, o_version_b, o_samples_two, o_lane0_mismatch, l0_valid;
	slpc_err_events_s err_ev;
	slpc_params_s l0_params, o_params;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	slpc_regs i_dut (.i_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
		.i_err_events(err_ev), .i_lane0_valid(l0_valid), .i_lane0_params(l0_params),
		.o_params, .o_version_b, .o_samples_two, .o_lane0_mismatch);
	slpc_lane_tx i_tx (.i_clk, .o_err_events(err_ev), .o_lane0_valid(l0_valid),
		.o_lane0_params(l0_params));
	always #5 i_clk = ~i_clk;
	task automatic summarize();
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// the longest scenario is the 260-pulse saturation run
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_wr = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_wr = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_rd = 1'b1;
		i_addr = a;
		@(negedge i_clk);
		i_rd = 1'b0;
		chk(o_rvalid, 1'b1);
		chk(o_rdata, e);
	endtask
	task automatic t_reset();
		rd(OFS_SUBCLASS_AND_BITS, {RST_SUBCLASS, RST_BITS});
		rd(OFS_SAMPLES_AND_VERSION, {RST_VERSION, RST_SAMPLES});
		rd(OFS_DENSITY_AND_CTRL, 8'h80);
		rd(OFS_LANE0_PARAM_CHECKSUM, 8'h45);
		rd(OFS_LANE_ERR_CNT_MONITOR, 8'h00);
		chk(o_version_b, 1'b1);
		chk(o_samples_two, 1'b0);
	endtask
	task automatic t_fields();
		wr(OFS_SAMPLES_AND_VERSION, 8'h01);
		rd(OFS_SAMPLES_AND_VERSION, 8'h01);
		chk(o_version_b, 1'b0);
		chk(o_samples_two, 1'b1);
		wr(OFS_SAMPLES_AND_VERSION, 8'h21);
		// decoded flags trail the register by one cycle
		@(negedge i_clk);
		chk(o_version_b, 1'b1);
		wr(OFS_DENSITY_AND_CTRL, 8'h60);
		rd(OFS_DENSITY_AND_CTRL, 8'h00);
		wr(OFS_DENSITY_AND_CTRL, 8'hE0);
		rd(OFS_DENSITY_AND_CTRL, 8'h80);
		wr(12'h460, 8'hAA);
		rd(12'h460, 8'h00);
		// unmapped parameter bytes read zero, so they add nothing
		wr(OFS_LANE0_PARAM_CHECKSUM, 8'h2F + 8'h21 + 8'h80);
		rd(OFS_LANE0_PARAM_CHECKSUM, 8'hD0);
	endtask
	task automatic t_lane0();
		slpc_params_s p;
		p = '{3'h1, 5'h0F, 3'h1, 5'h01, 1'b1, 5'h00, 8'hD0};
		chk(o_params, p);
		p.lane_zero_param_sum = 8'hD1;
		i_tx.send(p);
		chk(o_lane0_mismatch, 1'b1);
		p.lane_zero_param_sum = 8'hD0;
		i_tx.send(p);
		chk(o_lane0_mismatch, 1'b0);
	endtask
	task automatic t_counters();
		for (int k = 0; k < 3; k++)
			i_tx.pulse(2'(k), 3'(3 * k + 1), k + 2, k);
		for (int k = 0; k < 3; k++) begin
			wr(OFS_LANE_ERR_CNT_MONITOR, {1'b0, 3'(3 * k + 1), 2'b00, 2'(k)});
			rd(OFS_LANE_ERR_CNT_MONITOR, 8'(k + 2));
			wr(OFS_LANE_ERR_CNT_MONITOR, {1'b0, 3'(3 * k + 2), 2'b00, 2'(k)});
			rd(OFS_LANE_ERR_CNT_MONITOR, 8'h00);
		end
		wr(OFS_LANE_ERR_CNT_MONITOR, 8'h13);
		rd(OFS_LANE_ERR_CNT_MONITOR, 8'h00);
		i_tx.pulse(2'h0, 3'h5, 260, 0);
		wr(OFS_LANE_ERR_CNT_MONITOR, 8'h50);
		rd(OFS_LANE_ERR_CNT_MONITOR, 8'hFF);
	endtask
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		t_reset();
		t_fields();
		t_lane0();
		t_counters();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
